/* csm_pkg.sv */
package csm_pkg;
    // ********************************
    // Widths
    // ********************************
    localparam int DATA_W = 8;
    localparam int CH_W = 16;
    localparam int TEMP_W = 10;
    localparam int STEPS_W = 9;
    localparam int PRE_W = 17;

    // ********************************
    // Register offsets
    // ********************************
    localparam logic [7:0] A_GAIN = 8'hb9;
    localparam logic [7:0] A_TEMP_HI = 8'hd1;
    localparam logic [7:0] A_TEMP_LO = 8'hd2;
    localparam logic [7:0] A_TEMP_CTRL = 8'hd3;
    localparam logic [7:0] A_PERIOD = 8'hd9;
    localparam logic [7:0] A_GAP = 8'hda;
    localparam logic [7:0] A_BANK = 8'hdb;
    localparam logic [7:0] A_N_LO = 8'hdc;
    localparam logic [7:0] A_N_HI = 8'hdd;
    localparam logic [7:0] A_Y_LO = 8'hde;
    localparam logic [7:0] A_Y_HI = 8'hdf;
    localparam logic [7:0] A_Z_LO = 8'hec;
    localparam logic [7:0] A_Z_HI = 8'hed;
    localparam logic [7:0] A_X_LO = 8'hee;
    localparam logic [7:0] A_X_HI = 8'hef;
    localparam logic [7:0] A_IRQ_CLR = 8'hf8;
    localparam logic [7:0] A_IRQ_EN = 8'hf9;
    localparam logic [7:0] A_ACQ = 8'hfa;

    // ********************************
    // Field positions and codes
    // ********************************
    localparam int TEMP_DONE_B = 7;
    localparam int TEMP_START_B = 5;
    localparam int SEL_MSB = 3;
    localparam logic [3:0] SEL_CONVERT = 4'h4;
    localparam int BANK_B = 7;
    localparam int LED_CURRENT_LIMIT_LSB = 6;
    localparam int GAIN_LSB = 0;
    localparam int LATCH_B = 7;
    localparam int WAIT_B = 3;
    localparam int RUN_B = 1;
    localparam int PWR_B = 0;
    localparam int CLR_B = 2;
    localparam int IRQ_EN_LSB = 1;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hff;
    localparam logic [7:0] GAP_RST = 8'hff;
    localparam logic [7:0] ACQ_RST = 8'h00;

    // ********************************
    // Timing
    // ********************************
    localparam real STEP_TIME_MS = 2.8;
    localparam real CLK_MHZ = 40.0;
    localparam int STEP_CYCLES = int'(STEP_TIME_MS * 1000.0 * CLK_MHZ);
    localparam logic [8:0] STEPS_FULL = 9'h100;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_INTEG,
        SEQ_GAP
    } csm_seq_t;
endpackage

/* csm_step_timer.sv */
`timescale 1ns/1ps
module csm_step_timer #(
    parameter int STEP_CYCLES = csm_pkg::STEP_CYCLES
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Control
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic [csm_pkg::STEPS_W-1:0] i_steps,
    // Status
    output logic o_busy,
    output logic o_done
);
    import csm_pkg::*;

    logic [PRE_W-1:0] pre;
    logic [STEPS_W-1:0] left;
    logic last_tick;

    assign last_tick = (pre == PRE_W'(STEP_CYCLES - 1));

    // ********************************
    // Prescaler and step count
    // ********************************
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || i_abort) begin
            pre <= '0;
            left <= '0;
            o_busy <= 1'b0;
        end else if (i_start) begin
            pre <= '0;
            left <= i_steps;
            o_busy <= 1'b1;
        end else if (o_busy) begin
            pre <= last_tick ? '0 : pre + 1'b1;
            if (last_tick) begin
                left <= left - 1'b1;
                o_busy <= (left != 9'h001);
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_done <= 1'b0;
        end else begin
            o_done <= o_busy && last_tick && left == 9'h001 && !i_start && !i_abort;
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    step_count_a: assert property (
        o_done |-> $past(pre) == PRE_W'(STEP_CYCLES - 1) && $past(left) == 9'h001)
        else $error("timer ended before its last step");
endmodule

/* csm_measure_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Temp bits 9:2 read at high byte
// - Temp bits 1:0 read at low byte
// - Done flag sets at conversion end
// - Start bit with the convert select code launches conversion; zero idles
// - Bank bit picks blue or Z/NEAR_INFRARED_CHANNEL
// - Bits 7:6 set LED current limit
// - Bits 1:0 set common channel gain
// - Integration lasts 256-minus-byte steps
// - Wait lasts 256-minus-byte steps
// - Latch bit captures results after acquisition
// - Wait bit enables pause between acquisitions
// - Run bit enables acquisitions
// - Channel results read as byte pairs
// - Clear bit drops data ready when enabled
module csm_measure_ctrl #(
    parameter int STEP_CYCLES = csm_pkg::STEP_CYCLES
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [csm_pkg::DATA_W-1:0] i_reg_addr,
    input wire logic [csm_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [csm_pkg::DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Sensor front end
    input wire logic [csm_pkg::CH_W-1:0] i_adc_x,
    input wire logic [csm_pkg::CH_W-1:0] i_adc_y,
    input wire logic [csm_pkg::CH_W-1:0] i_adc_z,
    input wire logic [csm_pkg::CH_W-1:0] i_adc_nir,
    input wire logic [csm_pkg::CH_W-1:0] i_adc_b440,
    input wire logic [csm_pkg::CH_W-1:0] i_adc_b490,
    input wire logic [csm_pkg::TEMP_W-1:0] i_temp_value,
    input wire logic i_temp_done,
    // Analog controls and data ready status
    output logic [1:0] o_gain,
    output logic [1:0] o_led_current,
    output logic o_integrating,
    output logic o_temp_convert,
    output logic o_data_ready
);
    import csm_pkg::*;

    // ********************************
    // Storage
    // ********************************
    logic [7:0] period;
    logic [7:0] gap;
    logic bank;
    logic latch_en;
    logic wait_en;
    logic run_en;
    logic power_on;
    logic [1:0] irq_en;
    logic temp_done_flag;
    logic temp_start;
    logic [3:0] conversion_select_code;
    logic [TEMP_W-1:0] temperature_result;
    logic [CH_W-1:0] x_data;
    logic [CH_W-1:0] y_data;
    logic [CH_W-1:0] z_data;
    logic [CH_W-1:0] n_data;
    csm_seq_t state;
    csm_seq_t next_state;
    logic tmr_start;
    logic tmr_abort;
    logic [STEPS_W-1:0] tmr_steps;
    logic tmr_busy;
    logic tmr_done;
    logic acq_end;
    logic temp_finish;
    logic [7:0] rd_value;
    logic [STEPS_W-1:0] period_steps;
    logic [STEPS_W-1:0] gap_steps;

    function automatic logic wr_at(input logic [7:0] a);
        wr_at = i_reg_wr && (i_reg_addr == a);
    endfunction

    assign period_steps = STEPS_FULL - {1'b0, period};
    assign gap_steps = STEPS_FULL - {1'b0, gap};
    assign temp_finish = o_temp_convert && i_temp_done;

    // ********************************
    // Gain and LED current
    // ********************************
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_led_current <= GAIN_RST[LED_CURRENT_LIMIT_LSB+:2];
            o_gain <= GAIN_RST[GAIN_LSB+:2];
        end else if (wr_at(A_GAIN)) begin
            o_led_current <= i_reg_wdata[LED_CURRENT_LIMIT_LSB+:2];
            o_gain <= i_reg_wdata[GAIN_LSB+:2];
        end
    end

    // ********************************
    // Timing and acquisition setup
    // ********************************
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            period <= PERIOD_RST;
            gap <= GAP_RST;
        end else begin
            if (wr_at(A_PERIOD)) begin
                period <= i_reg_wdata;
            end
            if (wr_at(A_GAP)) begin
                gap <= i_reg_wdata;
            end
        end
    end

    // Reserved bits are not stored, so they always read back as zero
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            latch_en <= ACQ_RST[LATCH_B];
            wait_en <= ACQ_RST[WAIT_B];
            run_en <= ACQ_RST[RUN_B];
            power_on <= ACQ_RST[PWR_B];
        end else if (wr_at(A_ACQ)) begin
            latch_en <= i_reg_wdata[LATCH_B];
            wait_en <= i_reg_wdata[WAIT_B];
            run_en <= i_reg_wdata[RUN_B];
            power_on <= i_reg_wdata[PWR_B];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            bank <= 1'b0;
        end else if (wr_at(A_BANK)) begin
            bank <= i_reg_wdata[BANK_B];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            irq_en <= 2'h0;
        end else if (wr_at(A_IRQ_EN)) begin
            irq_en <= i_reg_wdata[IRQ_EN_LSB+:2];
        end
    end

    // ********************************
    // Temperature conversion
    // ********************************
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            temp_start <= 1'b0;
            conversion_select_code <= 4'h0;
        end else if (wr_at(A_TEMP_CTRL)) begin
            temp_start <= i_reg_wdata[TEMP_START_B];
            conversion_select_code <= i_reg_wdata[SEL_MSB:0];
        end
    end

    // A start without the convert select code stays idle
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_temp_convert <= 1'b0;
        end else if (wr_at(A_TEMP_CTRL)) begin
            o_temp_convert <= i_reg_wdata[TEMP_START_B] &&
                i_reg_wdata[SEL_MSB:0] == SEL_CONVERT;
        end else if (temp_finish) begin
            o_temp_convert <= 1'b0;
        end
    end

    // Set wins over the clear that every temperature control write performs
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            temp_done_flag <= 1'b0;
        end else if (temp_finish) begin
            temp_done_flag <= 1'b1;
        end else if (wr_at(A_TEMP_CTRL)) begin
            temp_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            temperature_result <= '0;
        end else if (temp_finish) begin
            temperature_result <= i_temp_value;
        end
    end

    // ********************************
    // Acquisition sequencer
    // ********************************
    csm_step_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_start(tmr_start),
        .i_abort(tmr_abort),
        .i_steps(tmr_steps),
        .o_busy(tmr_busy),
        .o_done(tmr_done)
    );

    always_comb begin
        next_state = state;
        tmr_start = 1'b0;
        tmr_abort = 1'b0;
        tmr_steps = period_steps;
        acq_end = 1'b0;
        unique case (state)
            SEQ_IDLE: begin
                if (run_en) begin
                    tmr_start = 1'b1;
                    next_state = SEQ_INTEG;
                end
            end
            SEQ_INTEG: begin
                if (!run_en) begin
                    tmr_abort = 1'b1;
                    next_state = SEQ_IDLE;
                end else if (tmr_done) begin
                    acq_end = 1'b1;
                    tmr_start = 1'b1;
                    if (wait_en) begin
                        tmr_steps = gap_steps;
                        next_state = SEQ_GAP;
                    end
                end
            end
            SEQ_GAP: begin
                if (!run_en) begin
                    tmr_abort = 1'b1;
                    next_state = SEQ_IDLE;
                end else if (tmr_done) begin
                    tmr_start = 1'b1;
                    next_state = SEQ_INTEG;
                end
            end
            default: begin
                tmr_abort = 1'b1;
                next_state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state <= SEQ_IDLE;
            o_integrating <= 1'b0;
        end else begin
            state <= next_state;
            o_integrating <= (next_state == SEQ_INTEG);
        end
    end

    // ********************************
    // Result capture and data ready
    // ********************************
    // Results only move on a completed acquisition, so reads stay coherent
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            x_data <= '0;
            y_data <= '0;
            z_data <= '0;
            n_data <= '0;
        end else if (acq_end && latch_en) begin
            x_data <= i_adc_x;
            y_data <= i_adc_y;
            z_data <= bank ? i_adc_z : i_adc_b490;
            n_data <= bank ? i_adc_nir : i_adc_b440;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_data_ready <= 1'b0;
        end else if (acq_end) begin
            o_data_ready <= 1'b1;
        end else if (wr_at(A_IRQ_CLR) && i_reg_wdata[CLR_B] && irq_en != 2'h0) begin
            o_data_ready <= 1'b0;
        end
    end

    // ********************************
    // Register read
    // ********************************
    always_comb begin
        rd_value = 8'h00;
        unique case (i_reg_addr)
            A_GAIN: rd_value = {o_led_current, 4'h0, o_gain};
            A_TEMP_HI: rd_value = temperature_result[9:2];
            A_TEMP_LO: rd_value = {6'h00, temperature_result[1:0]};
            A_TEMP_CTRL: rd_value = {temp_done_flag, 1'b0, temp_start, 1'b0, conversion_select_code};
            A_PERIOD: rd_value = period;
            A_GAP: rd_value = gap;
            A_BANK: rd_value = {bank, 7'h00};
            A_N_LO: rd_value = n_data[7:0];
            A_N_HI: rd_value = n_data[15:8];
            A_Y_LO: rd_value = y_data[7:0];
            A_Y_HI: rd_value = y_data[15:8];
            A_Z_LO: rd_value = z_data[7:0];
            A_Z_HI: rd_value = z_data[15:8];
            A_X_LO: rd_value = x_data[7:0];
            A_X_HI: rd_value = x_data[15:8];
            A_IRQ_CLR: rd_value = {5'h00, irq_en != 2'h0, 2'h0};
            A_IRQ_EN: rd_value = {5'h00, irq_en, 1'b0};
            A_ACQ: rd_value = {latch_en, 3'h0, wait_en, 1'b0, run_en, power_on};
            default: rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rd_value;
            end
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    sequence temp_launch_s;
        wr_at(A_TEMP_CTRL) && i_reg_wdata[TEMP_START_B] && i_reg_wdata[SEL_MSB:0] == SEL_CONVERT;
    endsequence

    sequence temp_end_s;
        o_temp_convert && i_temp_done;
    endsequence

    temp_high_read_a: assert property (
        i_reg_rd && i_reg_addr == A_TEMP_HI |=> o_reg_rvalid && o_reg_rdata == $past(temperature_result[9:2]))
        else $error("temperature high byte wrong");

    temp_low_read_a: assert property (
        i_reg_rd && i_reg_addr == A_TEMP_LO |=> o_reg_rdata == {6'h00, $past(temperature_result[1:0])})
        else $error("temperature low byte wrong");

    temp_done_set_a: assert property (
        temp_end_s |=> temp_done_flag && !o_temp_convert && temperature_result == $past(i_temp_value))
        else $error("conversion end not flagged");

    temp_launch_a: assert property (
        temp_launch_s |=> o_temp_convert && !temp_done_flag)
        else $error("conversion did not start");

    temp_idle_a: assert property (
        wr_at(A_TEMP_CTRL) && !i_reg_wdata[TEMP_START_B] |=> !o_temp_convert)
        else $error("conversion did not return to idle");

    bank_route_a: assert property (
        acq_end && latch_en && bank |=> n_data == $past(i_adc_nir) && z_data == $past(i_adc_z))
        else $error("bank one routing wrong");

    gain_drive_a: assert property (
        wr_at(A_GAIN) |=> o_led_current == $past(i_reg_wdata[7:6]) && o_gain == $past(i_reg_wdata[1:0]))
        else $error("gain or current field not applied");

    latch_hold_a: assert property (
        !(acq_end && latch_en) |=> $stable(x_data) && $stable(y_data))
        else $error("results moved without a latched acquisition");

    no_wait_a: assert property (
        acq_end && !wait_en |=> state == SEQ_INTEG && o_integrating)
        else $error("pause inserted while wait disabled");

    wait_gap_a: assert property (
        acq_end && wait_en |=> state == SEQ_GAP && tmr_busy && !o_integrating)
        else $error("wait interval skipped");

    run_off_a: assert property (
        !run_en ##1 !run_en |=> !o_integrating && !tmr_busy)
        else $error("integration running while disabled");

    ready_set_a: assert property (
        state == SEQ_INTEG && run_en && tmr_done |=> o_data_ready)
        else $error("data ready not raised");

    ready_clear_a: assert property (
        wr_at(A_IRQ_CLR) && i_reg_wdata[CLR_B] && irq_en != 2'h0 && !acq_end |=> !o_data_ready)
        else $error("data ready not cleared");
endmodule

/* csm_sensor_model.sv */
`timescale 1ns/1ps
// ********************************
// Analog front end stand-in
// ********************************
module csm_sensor_model #(
    parameter int TDLY = 20,
    parameter logic [9:0] TEMP = 10'h2b6,
    parameter logic [15:0] VX = 16'h1a2b,
    parameter logic [15:0] VY = 16'h3c4d,
    parameter logic [15:0] VZ = 16'h5e6f,
    parameter logic [15:0] VN = 16'h7081,
    parameter logic [15:0] VB4 = 16'h92a3,
    parameter logic [15:0] VB9 = 16'hb4c5
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Conversion request
    input wire logic i_temp_convert,
    // Results
    output logic [15:0] o_adc_x,
    output logic [15:0] o_adc_y,
    output logic [15:0] o_adc_z,
    output logic [15:0] o_adc_nir,
    output logic [15:0] o_adc_b440,
    output logic [15:0] o_adc_b490,
    output logic [9:0] o_temp_value,
    output logic o_temp_done
);
    int cnt;
    assign o_adc_x = VX;
    assign o_adc_y = VY;
    assign o_adc_z = VZ;
    assign o_adc_nir = VN;
    assign o_adc_b440 = VB4;
    assign o_adc_b490 = VB9;
    // Value is only meaningful with the done pulse; inverse otherwise
    assign o_temp_value = o_temp_done ? TEMP : ~TEMP;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || !i_temp_convert) begin
            cnt <= 0;
            o_temp_done <= 1'b0;
        end else begin
            o_temp_done <= (cnt == TDLY);
            if (cnt <= TDLY) begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

/* test_color_sensor_measure_ctrl.sv */
`timescale 1ns/1ps
module test_color_sensor_measure_ctrl;
    import csm_pkg::*;
    localparam logic [9:0] TEMP = 10'h2b6;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] o_reg_rdata;
    logic o_reg_rvalid;
    logic [15:0] ax, ay, az, an, ab4, ab9;
    logic [9:0] tv;
    logic td;
    logic [1:0] o_gain, o_led_current;
    logic o_integrating, o_temp_convert, o_data_ready;
    int n_errors = 0;
    int n_compared = 0;
    logic [7:0] d;
    int h1, h2, lo_len, k;
    logic acc;

    csm_measure_ctrl #(.STEP_CYCLES(4)) i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_adc_x(ax), .i_adc_y(ay),
        .i_adc_z(az), .i_adc_nir(an), .i_adc_b440(ab4), .i_adc_b490(ab9), .i_temp_value(tv),
        .i_temp_done(td), .o_gain(o_gain), .o_led_current(o_led_current),
        .o_integrating(o_integrating), .o_temp_convert(o_temp_convert), .o_data_ready(o_data_ready));
    csm_sensor_model #(.TEMP(TEMP)) i_model (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_temp_convert(o_temp_convert), .o_adc_x(ax), .o_adc_y(ay), .o_adc_z(az), .o_adc_nir(an),
        .o_adc_b440(ab4), .o_adc_b490(ab9), .o_temp_value(tv), .o_temp_done(td));

    initial begin
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    // ********************************
    // Access and check tasks
    // ********************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= v;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk("read valid", 8'h01, {7'h00, o_reg_rvalid});
        v = o_reg_rdata;
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(what, e, v & m);
    endtask
    function automatic logic sig(input int s);
        return (s == 0) ? o_integrating : (s == 1) ? o_temp_convert : o_data_ready;
    endfunction
    task automatic wait_for(input int s, input logic lvl, input int lim);
        int n;
        n = 0;
        while (sig(s) !== lvl && n < lim) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        if (sig(s) !== lvl) begin
            n_errors++;
            $display("wrong value wait on output %0d expected %b seen %b", s, lvl, sig(s));
        end
    endtask
    task automatic run_len(input int s, input logic lvl, output int len);
        len = 0;
        while (sig(s) === lvl && len < 2000) begin
            @(posedge i_ref_clk);
            #1;
            len++;
        end
    endtask
    task automatic clear_ready;
        wr(A_IRQ_CLR, 8'h04);
        @(posedge i_ref_clk);
        #1;
        chk("ready cleared", 8'h00, {7'h00, o_data_ready});
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        n_errors++;
        end_sim;
    end

    // ********************************
    // Tests
    // ********************************
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        rchk("gain reset", A_GAIN, 8'hff, GAIN_RST);
        rchk("period reset", A_PERIOD, 8'hff, 8'hff);
        rchk("gap reset", A_GAP, 8'hff, 8'hff);
        rchk("bank reset", A_BANK, 8'hff, 8'h00);
        rchk("acq reset", A_ACQ, 8'hff, 8'h00);
        rchk("temp ctrl reset", A_TEMP_CTRL, 8'hff, 8'h00);
        rchk("unmapped", 8'h10, 8'hff, 8'h00);
        $display("test reset values done");

        for (k = 0; k < 4; k++) begin
            wr(A_GAIN, {k[1:0], 4'h0, ~k[1:0]});
            @(posedge i_ref_clk);
            #1;
            chk("led current", {6'h00, k[1:0]}, {6'h00, o_led_current});
            chk("gain", {6'h00, ~k[1:0]}, {6'h00, o_gain});
            rchk("gain readback", A_GAIN, 8'hff, {k[1:0], 4'h0, ~k[1:0]});
        end
        $display("test gain and current done");

        wr(A_TEMP_CTRL, 8'h21);
        repeat (4) @(posedge i_ref_clk);
        #1;
        chk("bad select idle", 8'h00, {7'h00, o_temp_convert});
        wr(A_TEMP_CTRL, 8'h24);
        wait_for(1, 1'b1, 4);
        wr(A_TEMP_CTRL, 8'h00);
        @(posedge i_ref_clk);
        #1;
        chk("abort convert", 8'h00, {7'h00, o_temp_convert});
        repeat (30) @(posedge i_ref_clk);
        rchk("no done after abort", A_TEMP_CTRL, 8'h80, 8'h00);
        wr(A_TEMP_CTRL, 8'h24);
        wait_for(1, 1'b1, 4);
        wait_for(1, 1'b0, 40);
        rchk("done flag", A_TEMP_CTRL, 8'h80, 8'h80);
        rchk("temp high", A_TEMP_HI, 8'hff, TEMP[9:2]);
        rchk("temp low", A_TEMP_LO, 8'h03, {6'h00, TEMP[1:0]});
        wr(A_TEMP_CTRL, 8'h00);
        rchk("done cleared", A_TEMP_CTRL, 8'h80, 8'h00);
        $display("test temperature done");

        acc = 1'b0;
        repeat (30) begin
            @(posedge i_ref_clk);
            #1;
            acc = acc | o_integrating;
        end
        chk("no run no integ", 8'h00, {7'h00, acc});
        wr(A_IRQ_EN, 8'h02);
        wr(A_PERIOD, 8'hfd);
        wr(A_BANK, 8'h80);
        wr(A_ACQ, 8'h03);
        wait_for(2, 1'b1, 100);
        rchk("no latch", A_X_LO, 8'hff, 8'h00);
        rchk("clear reads one", A_IRQ_CLR, 8'h04, 8'h04);
        wr(A_ACQ, 8'h83);
        clear_ready;
        wait_for(2, 1'b1, 100);
        clear_ready;
        wait_for(2, 1'b1, 100);
        rchk("y lo", A_Y_LO, 8'hff, 8'h4d);
        rchk("y hi", A_Y_HI, 8'hff, 8'h3c);
        rchk("x lo", A_X_LO, 8'hff, 8'h2b);
        rchk("x hi", A_X_HI, 8'hff, 8'h1a);
        rchk("z lo bank1", A_Z_LO, 8'hff, 8'h6f);
        rchk("z hi bank1", A_Z_HI, 8'hff, 8'h5e);
        rchk("n lo bank1", A_N_LO, 8'hff, 8'h81);
        rchk("n hi bank1", A_N_HI, 8'hff, 8'h70);
        wr(A_BANK, 8'h00);
        clear_ready;
        wait_for(2, 1'b1, 100);
        clear_ready;
        wait_for(2, 1'b1, 100);
        rchk("z lo bank0", A_Z_LO, 8'hff, 8'hc5);
        rchk("z hi bank0", A_Z_HI, 8'hff, 8'hb4);
        rchk("n lo bank0", A_N_LO, 8'hff, 8'ha3);
        rchk("n hi bank0", A_N_HI, 8'hff, 8'h92);
        // Stop acquisitions so that a fresh end cannot mask a clear that should be refused
        wr(A_ACQ, 8'h81);
        wr(A_IRQ_EN, 8'h00);
        wr(A_IRQ_CLR, 8'h04);
        @(posedge i_ref_clk);
        #1;
        chk("clear refused", 8'h01, {7'h00, o_data_ready});
        wr(A_IRQ_EN, 8'h02);
        $display("test results and banks done");

        wr(A_GAP, 8'hfe);
        wr(A_ACQ, 8'h8b);
        wait_for(0, 1'b0, 100);
        wait_for(0, 1'b1, 100);
        run_len(0, 1'b1, h1);
        run_len(0, 1'b0, lo_len);
        chk("gap length", 8'h09, lo_len[7:0]);
        chk("integ length", 8'h0d, h1[7:0]);
        wr(A_PERIOD, 8'hfb);
        wait_for(0, 1'b0, 100);
        wait_for(0, 1'b1, 100);
        run_len(0, 1'b1, h2);
        chk("integ step", 8'h08, h2[7:0] - h1[7:0]);
        wr(A_PERIOD, 8'hfd);
        wr(A_ACQ, 8'h83);
        wait_for(0, 1'b1, 100);
        clear_ready;
        acc = 1'b0;
        repeat (40) begin
            @(posedge i_ref_clk);
            #1;
            acc = acc | ~o_integrating;
        end
        chk("no pause", 8'h00, {7'h00, acc});
        chk("ready again", 8'h01, {7'h00, o_data_ready});
        wr(A_ACQ, 8'h01);
        repeat (2) @(posedge i_ref_clk);
        #1;
        chk("run off stops", 8'h00, {7'h00, o_integrating});
        $display("test acquisition timing done");
        end_sim;
    end
endmodule
